// >>> common/port_expander_pkg.sv
// Operation
// R1: eight pins, each input or output; a pin is input while its latch is high
// R2: after reset every output latch is high, only weak pull-up active
// R3: pin written high gets strong pull-up until next SCL falling edge
// R4: master should write a latch high before using that pin as input
// R5: open-drain active-low change alert output for a host interrupt
// R6: any edge on an input-use pin asserts the alert after alert delay
// R7: alert clears on return to original levels or on own port access
// R8: read clears at ack after SCL rise, write at ack after SCL fall
// R9: pin changes during the ack pulse may be lost or give short alert
// R10: after clearing, each new change is signalled after next clock edge
// R11: transfers to other addresses leave the alert untouched
// R12: master frames each transfer with start and stop conditions
// R13: address byte arrives msb first, direction bit last, shifted in so
// R14: general call address is never acknowledged
// R15: matching address acknowledged by SDA low through ack high phase
// R16: address-select inputs stay stable from start to stop
// R17: direction high sends one byte of sampled pin levels; code sends a fresh byte after each master ack
// R18: direction low takes one byte, acknowledges it, drives the latches
// R19: further written bytes in the same transfer are ignored
// R20: latches change only after a whole byte is received and acknowledged
// R21: new outputs appear in ack cycle, output delay after SCL rise
// R22: address is 0111 followed by address-select pins, 38h to 3Fh
// R23: data bit 7 maps to pin 7, bit 0 to pin 0
package port_expander_pkg;

    // ----------------------------------------------------------------
    // widths and fixed values
    // ----------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_SEL_W = 3;
    localparam int CNT_W = 4;
    localparam logic [3:0] ADDR_FIXED = 4'h7;
    localparam logic [7:0] LATCH_RESET = 8'hff;
    localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
    localparam logic [CNT_W-1:0] FIRST_BIT = 4'h1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ALERT_VALID_NS = 8;
    localparam int OUTPUT_VALID_NS = 8;
    // longest times: round down, never below one cycle
    localparam int ALERT_VALID_CYC =
        (ALERT_VALID_NS / CLK_PERIOD_NS < 1) ? 1 : ALERT_VALID_NS / CLK_PERIOD_NS;
    localparam int OUTPUT_VALID_CYC =
        (OUTPUT_VALID_NS / CLK_PERIOD_NS < 1) ? 1 : OUTPUT_VALID_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100,
        ST_RX = 3'b101,
        ST_RX_ACK = 3'b110,
        ST_IGNORE = 3'b111
    } xfer_state_t;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } i2c_line_t;

    typedef struct packed
    {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_event_t;

endpackage

// >>> design/bit_sync.sv
`timescale 1ns/1ps
module bit_sync
    import port_expander_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '1
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // two stages; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end
        else if (ce)
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// >>> design/port_change_alert.sv
`timescale 1ns/1ps
module port_change_alert
    import port_expander_pkg::*;
#(
    parameter int W = PORT_W,
    parameter int DELAY_CYC = ALERT_VALID_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] latch,
    input wire logic clear,
    output logic alert_oe_n
);

    logic [W-1:0] ref_level;
    logic [DELAY_CYC-1:0] pipe;
    logic mismatch;

    // only pins whose latch is high count as inputs
    assign mismatch = |((level ^ ref_level) & latch[W-1:0]); // R1 R6 R7

    // reference snapshot; a change landing on the clear cycle is absorbed
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ref_level <= LATCH_RESET[W-1:0];
        else if (ce && clear)
            ref_level <= level; // R7 R9
    end

    // delay line models the alert valid time
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pipe <= '0;
        else if (ce)
        begin
            if (clear)
                pipe <= '0; // R8
            else
                pipe <= DELAY_CYC'({pipe, mismatch}); // R6 R10
        end
    end

    // open drain: enable low pulls the line low
    always_ff @(posedge clk)
    begin
        if (!rstn)
            alert_oe_n <= 1'b1;
        else if (ce)
            alert_oe_n <= ~pipe[DELAY_CYC-1] | clear; // R5
    end

endmodule

// >>> design/i2c_quasi_bidir_port_expander.sv
`timescale 1ns/1ps
module i2c_quasi_bidir_port_expander
    import port_expander_pkg::*;
#(
    parameter int W = PORT_W,
    parameter int OUT_DELAY_CYC = OUTPUT_VALID_CYC,
    parameter int ALERT_DELAY_CYC = ALERT_VALID_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [ADDR_SEL_W-1:0] address_select_pins,
    input wire logic [W-1:0] port_pins_in,
    output logic [W-1:0] port_pins_out,
    output logic [W-1:0] port_pins_oe_n,
    output logic change_alert_out,
    output logic change_alert_n_oe_n
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    i2c_line_t line_raw;
    i2c_line_t line;
    i2c_line_t line_q;
    bus_event_t ev;
    logic [ADDR_SEL_W-1:0] addr_sel;
    logic [W-1:0] port_level;

    assign line_raw.scl = scl_in;
    assign line_raw.sda = sda_in;

    bit_sync #(.W(2), .RESET_VAL(2'h3)) u_line_sync
    (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .d(line_raw),
        .q(line)
    );

    bit_sync #(.W(ADDR_SEL_W), .RESET_VAL('0)) u_addr_sync
    (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .d(address_select_pins),
        .q(addr_sel)
    );

    bit_sync #(.W(W), .RESET_VAL('1)) u_port_sync
    (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .d(port_pins_in),
        .q(port_level)
    );

    // ----------------------------------------------------------------
    // bus event detection
    // ----------------------------------------------------------------

    // previous synced levels for edge finding
    always_ff @(posedge clk)
    begin
        if (!rstn)
            line_q <= 2'h3;
        else if (ce)
            line_q <= line;
    end

    // start and stop only count while scl stays high
    assign ev.rise = line.scl & ~line_q.scl;
    assign ev.fall = ~line.scl & line_q.scl;
    assign ev.start = line.scl & line_q.scl & line_q.sda & ~line.sda; // R12
    assign ev.stop = line.scl & line_q.scl & ~line_q.sda & line.sda; // R12

    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    xfer_state_t state;
    logic [CNT_W-1:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic rw;
    logic master_ack;
    logic sda_release;
    logic alert_clear;
    logic wr_stb;
    logic [W-1:0] wr_data;
    logic addr_match;

    // upper pattern fixed, so the general call can never match
    assign addr_match = (rx_shift[7:1] == {ADDR_FIXED, addr_sel}); // R14 R16 R22

    // state, counter and shift registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            bit_cnt <= '0;
            rx_shift <= '0;
            tx_shift <= '1;
            rw <= 1'b0;
            master_ack <= 1'b0;
            sda_release <= 1'b1;
        end
        else if (ce)
        begin
            if (ev.start)
            begin
                // repeated start restarts address phase
                state <= ST_ADDR;
                bit_cnt <= '0;
                sda_release <= 1'b1;
            end
            else if (ev.stop)
            begin
                state <= ST_IDLE;
                sda_release <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_ADDR:
                    begin
                        if (ev.rise)
                        begin
                            rx_shift <= {rx_shift[6:0], line.sda}; // R13
                            bit_cnt <= bit_cnt + FIRST_BIT;
                        end
                        else if (ev.fall && bit_cnt == BYTE_BITS)
                        begin
                            bit_cnt <= '0;
                            rw <= rx_shift[0]; // R13
                            if (addr_match)
                            begin
                                sda_release <= 1'b0; // R15
                                state <= ST_ADDR_ACK;
                            end
                            else
                                state <= ST_IGNORE; // R11 R14
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        if (ev.rise && rw)
                            tx_shift <= port_level; // R17 R23
                        else if (ev.fall)
                        begin
                            if (rw)
                            begin
                                sda_release <= tx_shift[7]; // R17
                                bit_cnt <= FIRST_BIT;
                                state <= ST_TX;
                            end
                            else
                            begin
                                sda_release <= 1'b1;
                                bit_cnt <= '0;
                                state <= ST_RX; // R18
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (ev.fall)
                        begin
                            if (bit_cnt == BYTE_BITS)
                            begin
                                sda_release <= 1'b1;
                                state <= ST_TX_ACK;
                            end
                            else
                            begin
                                tx_shift <= {tx_shift[6:0], 1'b1};
                                sda_release <= tx_shift[6]; // R17 R23
                                bit_cnt <= bit_cnt + FIRST_BIT;
                            end
                        end
                    end
                    ST_TX_ACK:
                    begin
                        if (ev.rise)
                        begin
                            master_ack <= ~line.sda;
                            tx_shift <= port_level;
                        end
                        else if (ev.fall)
                        begin
                            // master ack asks for a fresh sample
                            if (master_ack)
                            begin
                                sda_release <= tx_shift[7];
                                bit_cnt <= FIRST_BIT;
                                state <= ST_TX;
                            end
                            else
                                state <= ST_IGNORE;
                        end
                    end
                    ST_RX:
                    begin
                        if (ev.rise)
                        begin
                            rx_shift <= {rx_shift[6:0], line.sda}; // R23
                            bit_cnt <= bit_cnt + FIRST_BIT;
                        end
                        else if (ev.fall && bit_cnt == BYTE_BITS)
                        begin
                            sda_release <= 1'b0; // R18
                            state <= ST_RX_ACK;
                        end
                    end
                    ST_RX_ACK:
                    begin
                        if (ev.fall)
                        begin
                            sda_release <= 1'b1;
                            state <= ST_IGNORE; // R19
                        end
                    end
                    ST_IGNORE:
                        sda_release <= 1'b1; // R19
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // alert clear and write strobe, one cycle each, own address only
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            alert_clear <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= LATCH_RESET[W-1:0];
        end
        else if (ce)
        begin
            alert_clear <= 1'b0;
            wr_stb <= 1'b0;
            if (!ev.start && !ev.stop)
            begin
                if (state == ST_ADDR_ACK && ev.rise && rw)
                    alert_clear <= 1'b1; // R8 R11
                if (state == ST_RX && ev.fall && bit_cnt == BYTE_BITS)
                    alert_clear <= 1'b1; // R8 R11
                if (state == ST_RX_ACK && ev.rise)
                begin
                    wr_stb <= 1'b1; // R20
                    wr_data <= rx_shift[W-1:0]; // R23
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // port latches and strong pull-up
    // ----------------------------------------------------------------
    logic [OUT_DELAY_CYC-1:0] wr_pipe;
    logic [W-1:0] latch;
    logic [W-1:0] strong_pu;

    // delay line models the output valid time
    always_ff @(posedge clk)
    begin
        if (!rstn)
            wr_pipe <= '0;
        else if (ce)
            wr_pipe <= OUT_DELAY_CYC'({wr_pipe, wr_stb}); // R21
    end

    // latch only changes on an acknowledged whole byte
    always_ff @(posedge clk)
    begin
        if (!rstn)
            latch <= LATCH_RESET[W-1:0]; // R2
        else if (ce && wr_pipe[OUT_DELAY_CYC-1])
            latch <= wr_data; // R18 R20 R21
    end

    // strong pull-up lasts only until the next scl fall
    always_ff @(posedge clk)
    begin
        if (!rstn)
            strong_pu <= '0; // R2
        else if (ce)
        begin
            if (wr_pipe[OUT_DELAY_CYC-1])
                strong_pu <= wr_data; // R3
            else if (ev.fall)
                strong_pu <= '0; // R3
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------

    // low latch sinks, strong pull-up sources, else weak pull-up only
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            port_pins_out <= '0;
            port_pins_oe_n <= '1; // R2
        end
        else if (ce)
        begin
            port_pins_out <= strong_pu; // R3
            port_pins_oe_n <= latch & ~strong_pu; // R1
        end
    end

    // open-drain sda: data level is always low, enable picks drive
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            change_alert_out <= 1'b0;
        end
        else if (ce)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= sda_release; // R15
            change_alert_out <= 1'b0; // R5
        end
    end

    // ----------------------------------------------------------------
    // change alert
    // ----------------------------------------------------------------
    port_change_alert #(.W(W), .DELAY_CYC(ALERT_DELAY_CYC)) u_alert
    (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .level(port_level),
        .latch(latch),
        .clear(alert_clear),
        .alert_oe_n(change_alert_n_oe_n)
    );

endmodule

// >>> verif/port_expander_props.sv
`timescale 1ns/1ps
module port_expander_props
    import port_expander_pkg::*;
#(
    parameter int W = PORT_W,
    parameter int OUT_DELAY_CYC = OUTPUT_VALID_CYC,
    parameter int ALERT_DELAY_CYC = ALERT_VALID_CYC
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [ADDR_SEL_W-1:0] address_select_pins,
    input wire logic [W-1:0] port_pins_in,
    input wire logic [W-1:0] port_pins_out,
    input wire logic [W-1:0] port_pins_oe_n,
    input wire logic change_alert_out,
    input wire logic change_alert_n_oe_n
);
    // ----------------------------------------------------------------
    // pin age helper and properties
    // ----------------------------------------------------------------
    logic [3:0] pin_age;
    logic [W-1:0] pins_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // previous pin levels
    always_ff @(posedge clk)
    begin
        pins_q <= port_pins_in;
    end
    // cycles since any pin moved, saturating so it never wraps
    always_ff @(posedge clk)
    begin
        if (!rstn || pins_q != port_pins_in)
            pin_age <= 4'h0;
        else if (pin_age != 4'hf)
            pin_age <= pin_age + 4'h1;
    end
    sda_level_a: assert property (sda_out == 1'b0)
        else $error("sda drive level not low");
    alert_level_a: assert property (change_alert_out == 1'b0)
        else $error("alert drive level not low");
    reset_state_a: assert property ($rose(rstn) |-> port_pins_oe_n == LATCH_RESET
        && port_pins_out == '0 && change_alert_n_oe_n && sda_oe_n)
        else $error("outputs not at reset state");
    pullup_off_a: assert property ($fell(scl_in) |-> ##7 port_pins_out == '0)
        else $error("strong pull-up outlives scl fall");
    pin_drive_a: assert property ((port_pins_out & port_pins_oe_n) == '0)
        else $error("pull-up level on released pin");
    ack_hold_a: assert property ($rose(scl_in) && !sda_oe_n |-> !sda_oe_n [*5])
        else $error("sda released during clock high");
    sda_move_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda moved while scl high");
    alert_cause_a: assert property ($fell(change_alert_n_oe_n) |-> pin_age < 4'ha)
        else $error("alert without pin change");
    alert_clear_a: assert property ($rose(change_alert_n_oe_n) |->
        (pin_age < 4'ha) or (##[0:3] !sda_oe_n))
        else $error("alert cleared without access or revert");
    cover property ($fell(change_alert_n_oe_n));
    cover property (port_pins_out != '0);
    cover property ($rose(scl_in) && !sda_oe_n);
endmodule

bind i2c_quasi_bidir_port_expander port_expander_props #(.W(W), .OUT_DELAY_CYC(OUT_DELAY_CYC),
    .ALERT_DELAY_CYC(ALERT_DELAY_CYC)) props_i (.clk(clk), .rstn(rstn), .ce(ce),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pins(address_select_pins), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe_n(port_pins_oe_n),
    .change_alert_out(change_alert_out), .change_alert_n_oe_n(change_alert_n_oe_n));

// >>> verif/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // ----------------------------------------------------------------
    // bus master, half period of 5 clk gives an 80 ns link clock
    // ----------------------------------------------------------------
    // clock stands high between frames, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // sda moves one clk after scl falls, never together with it
    task automatic xbit(input logic b, output logic r);
        tick(1);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(5);
        r = sda;
        scl = 1'b0;
    endtask
    // also serves as a repeated start
    task automatic start();
        tick(1);
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_drv = 1'b0;
        tick(5);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(1);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_drv = 1'b1;
        tick(5);
    endtask
    // n below 8 leaves a partial byte with no ack bit
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic r;
        for (int i = 7; i > 7 - n; i--)
            xbit(d[i], r);
        ack = 1'b1;
        if (n == 8)
            xbit(1'b1, ack);
    endtask
    task automatic recv(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(mack, r);
    endtask
endmodule

// >>> verif/test_i2c_quasi_bidir_port_expander.sv
`timescale 1ns/1ps
module test_i2c_quasi_bidir_port_expander;
    import port_expander_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [7:0] ext_low = 8'h00;
    logic sda_out, sda_oe_n, alert_out, alert_oe_n, ka, kd;
    logic [7:0] pins_out, pins_oe_n, rdat;
    wire m_scl, m_sda, sda;
    wire [7:0] pins;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // ----------------------------------------------------------------
    // wiring, clock and watchdog
    // ----------------------------------------------------------------
    // sda has a pull-up; released pins see the weak pull-up unless pulled low
    assign sda = m_sda & (sda_oe_n | sda_out);
    assign pins = (pins_oe_n & ~ext_low) | (~pins_oe_n & pins_out);
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    i2c_master_model mst (.clk(clk), .sda(sda), .scl(m_scl), .sda_drv(m_sda));
    i2c_quasi_bidir_port_expander DUT (.clk(clk), .rstn(rstn), .ce(ce), .scl_in(m_scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pins(sel),
        .port_pins_in(pins), .port_pins_out(pins_out), .port_pins_oe_n(pins_oe_n),
        .change_alert_out(alert_out), .change_alert_n_oe_n(alert_oe_n));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        mst.start();
        mst.send({a, 1'b0}, 8, ka);
        mst.send(d, 8, kd);
        mst.stop();
    endtask
    task automatic rd();
        mst.start();
        mst.send({ADDR_FIXED, sel, 1'b1}, 8, ka);
        mst.recv(1'b1, rdat);
        mst.stop();
    endtask
    task automatic wait_alert(input logic lvl);
        for (int i = 0; i < 40 && alert_oe_n !== lvl; i++)
            mst.tick(1);
        chk("alert", {7'h0, lvl}, {7'h0, alert_oe_n});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_write_sel();
        for (int s = 0; s < 8; s++)
        begin
            sel = s[2:0];
            wr({ADDR_FIXED, sel}, 8'h5a ^ {s[2:0], 5'h0});
            chk("ack", 8'h00, {6'h0, ka, kd});
            chk("latch", 8'h5a ^ {s[2:0], 5'h0}, pins_oe_n);
            chk("pullup", 8'h00, pins_out);
        end
    endtask
    task automatic t_extra_partial();
        wr({ADDR_FIXED, sel}, 8'hc3);
        mst.start();
        mst.send({ADDR_FIXED, sel, 1'b0}, 8, ka);
        mst.send(8'h0f, 8, kd);
        mst.send(8'hf0, 8, kd);
        mst.stop();
        chk("extra nack", 8'h01, {7'h0, kd});
        chk("extra", 8'h0f, pins_oe_n);
        mst.start();
        mst.send({ADDR_FIXED, sel, 1'b0}, 8, ka);
        mst.send(8'hff, 4, kd);
        mst.stop();
        chk("partial", 8'h0f, pins_oe_n);
    endtask
    task automatic t_foreign();
        logic [6:0] other [3] = '{7'h00, {ADDR_FIXED, ~sel}, {4'h3, sel}};
        foreach (other[i])
        begin
            wr(other[i], 8'h00);
            chk("nack", 8'h01, {7'h0, ka});
            chk("kept", 8'h0f, pins_oe_n);
        end
    endtask
    task automatic t_read_alert();
        wr({ADDR_FIXED, sel}, 8'hff);
        rd();
        mst.tick(2);
        ext_low = 8'h14;
        wait_alert(1'b0);
        rd();
        chk("read", 8'heb, rdat);
        wait_alert(1'b1);
        ext_low = 8'h00;
        wait_alert(1'b0);
        ext_low = 8'h14;
        wait_alert(1'b1);
        ext_low = 8'h00;
        wait_alert(1'b0);
        wr(7'h00, 8'h00);
        wait_alert(1'b0);
        wr({ADDR_FIXED, sel}, 8'hff);
        wait_alert(1'b1);
        // ce low must hold the alert although a pin moves
        ce = 1'b0;
        ext_low = 8'h14;
        mst.tick(4);
        chk("frozen alert", 8'h01, {7'h0, alert_oe_n});
        ce = 1'b1;
        wait_alert(1'b0);
        ext_low = 8'h00;
        wait_alert(1'b1);
    endtask
    // ----------------------------------------------------------------
    // main sequence and verdict
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        mst.tick(4);
        rstn = 1'b1;
        mst.tick(4);
        chk("reset latch", LATCH_RESET, pins_oe_n);
        chk("reset alert", 8'h01, {7'h0, alert_oe_n});
        t_write_sel();
        t_extra_partial();
        t_foreign();
        t_read_alert();
        tally_and_finish();
    end
endmodule
